// File: verilog/vcmdac_core.sv
/*
 * I2C slave and output control of a 10-bit current-sink DAC that drives the
 * focus coil motor: control word storage, power-down, power-on hold and ramp.
 * Assumes an external I2C master on i_scl/i_sda, an open-drain wire resolved
 * outside from o_sda_oen, and a 50 MHz i_clk far above the serial clock.
 */
// Functional notes
// - The block answers as an I2C slave only at the 7-bit address 0x18.
// - The serial interface works at serial clocks up to 400 kHz.
// - A 10-bit code sets the sink current, full scale being 100 mA.
// - After reset the output code stays zero until a full word write lands.
// - Bit 15 of the word requests power-down, which forces the output off.
// - Bits 13 to 4 of the word carry the current code, MSB at bit 13.
// - Bits 3 to 0 pick how fast the output ramps to a new code.
// - Direction bit 0 writes the word and direction bit 1 reads it back.
`default_nettype none
`include "vcmdac_defs.svh"

module vcmdac_core #(
    parameter logic [15:0] RAMP_BASE_CYC = 16'(`VCMDAC_RAMP_TICK_CYC)
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_rst_n,
    input  wire logic                         i_scl,
    input  wire logic                         i_sda,
    output logic                              o_sda_oen,
    output logic [`VCMDAC_CODE_BITS-1:0]      o_current_code,
    output logic                              o_sleep,
    output logic                              o_word_loaded
);

    vcmdac_pkg::vcmdac_regs_t st_reg;
    vcmdac_pkg::vcmdac_regs_t st_next;

    logic                          scl_rise;
    logic                          scl_fall;
    logic                          bus_start;
    logic                          bus_stop;
    logic                          commit;
    logic [`VCMDAC_CODE_BITS-1:0]  target;
    logic [3:0]                    ramp_sel;
    logic [23:0]                   period;

    // Edges are taken from the second and third stages only.
    assign scl_rise  = st_reg.scl_q2 & ~st_reg.scl_q3;
    assign scl_fall  = ~st_reg.scl_q2 & st_reg.scl_q3;
    assign bus_start = st_reg.scl_q2 & st_reg.scl_q3 & st_reg.sda_q3 & ~st_reg.sda_q2;
    assign bus_stop  = st_reg.scl_q2 & st_reg.scl_q3 & ~st_reg.sda_q3 & st_reg.sda_q2;
    assign commit    = (st_reg.state == vcmdac_pkg::ST_WR) && scl_fall
                       && (st_reg.cnt == 4'h8) && st_reg.byte_idx;
    assign ramp_sel  = st_reg.word[`VCMDAC_RAMP_MSB:`VCMDAC_RAMP_LSB];
    assign period    = {8'h00, RAMP_BASE_CYC} << ramp_sel;
    // Power-down and the power-on hold both steer the output to zero.
    assign target    = (st_reg.word_valid && !st_reg.word[`VCMDAC_SLEEP_BIT])
                       ? st_reg.word[`VCMDAC_CODE_MSB:`VCMDAC_CODE_LSB]
                       : `VCMDAC_CODE_RESET;

    always_comb begin
        st_next = st_reg;
        st_next.scl_q1 = i_scl;
        st_next.scl_q2 = st_reg.scl_q1;
        st_next.scl_q3 = st_reg.scl_q2;
        st_next.sda_q1 = i_sda;
        st_next.sda_q2 = st_reg.sda_q1;
        st_next.sda_q3 = st_reg.sda_q2;
        if (bus_start) begin
            st_next.state    = vcmdac_pkg::ST_ADDR;
            st_next.cnt      = 4'h0;
            st_next.byte_idx = 1'b0;
            st_next.sda_oen  = 1'b1;
        end else if (bus_stop) begin
            st_next.state   = vcmdac_pkg::ST_IDLE;
            st_next.sda_oen = 1'b1;
        end else begin
            case (st_reg.state)
                vcmdac_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        st_next.shift = {st_reg.shift[6:0], st_reg.sda_q2};
                        st_next.cnt   = st_reg.cnt + 4'h1;
                    end else if (scl_fall && st_reg.cnt == 4'h8) begin
                        if (st_reg.shift[7:1] == `VCMDAC_I2C_ADDR) begin
                            st_next.state   = vcmdac_pkg::ST_AACK;
                            st_next.rw      = st_reg.shift[0];
                            st_next.sda_oen = 1'b0;
                        end else begin
                            st_next.state = vcmdac_pkg::ST_IDLE;
                        end
                    end
                end
                vcmdac_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        st_next.cnt = 4'h0;
                        if (st_reg.rw) begin
                            st_next.state   = vcmdac_pkg::ST_RD;
                            st_next.sda_oen = st_reg.word[15];
                            st_next.shift   = {st_reg.word[14:8], 1'b0};
                        end else begin
                            st_next.state   = vcmdac_pkg::ST_WR;
                            st_next.sda_oen = 1'b1;
                        end
                    end
                end
                vcmdac_pkg::ST_WR: begin
                    if (scl_rise) begin
                        st_next.shift = {st_reg.shift[6:0], st_reg.sda_q2};
                        st_next.cnt   = st_reg.cnt + 4'h1;
                    end else if (scl_fall && st_reg.cnt == 4'h8) begin
                        st_next.state   = vcmdac_pkg::ST_WACK;
                        st_next.sda_oen = 1'b0;
                        if (!st_reg.byte_idx) begin
                            st_next.hi_byte = st_reg.shift;
                        end else begin
                            st_next.word       = {st_reg.hi_byte, st_reg.shift};
                            st_next.word_valid = 1'b1;
                        end
                    end
                end
                vcmdac_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        st_next.state    = vcmdac_pkg::ST_WR;
                        st_next.sda_oen  = 1'b1;
                        st_next.cnt      = 4'h0;
                        st_next.byte_idx = ~st_reg.byte_idx;
                    end
                end
                vcmdac_pkg::ST_RD: begin
                    if (scl_rise) begin
                        st_next.cnt = st_reg.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st_reg.cnt == 4'h8) begin
                            st_next.state   = vcmdac_pkg::ST_RACK;
                            st_next.sda_oen = 1'b1;
                        end else begin
                            st_next.sda_oen = st_reg.shift[7];
                            st_next.shift   = {st_reg.shift[6:0], 1'b0};
                        end
                    end
                end
                vcmdac_pkg::ST_RACK: begin
                    if (scl_rise && st_reg.sda_q2) begin
                        st_next.state = vcmdac_pkg::ST_IDLE;
                    end else if (scl_fall) begin
                        st_next.state    = vcmdac_pkg::ST_RD;
                        st_next.cnt      = 4'h0;
                        st_next.byte_idx = ~st_reg.byte_idx;
                        if (st_reg.byte_idx) begin
                            st_next.sda_oen = st_reg.word[15];
                            st_next.shift   = {st_reg.word[14:8], 1'b0};
                        end else begin
                            st_next.sda_oen = st_reg.word[7];
                            st_next.shift   = {st_reg.word[6:0], 1'b0};
                        end
                    end
                end
                default: begin
                    st_next.state   = vcmdac_pkg::ST_IDLE;
                    st_next.sda_oen = 1'b1;
                end
            endcase
        end

        st_next.sleep = st_reg.word_valid & st_reg.word[`VCMDAC_SLEEP_BIT];
        // A zero ramp setting, power-down or the power-on hold moves at once.
        if (ramp_sel == 4'h0 || target == `VCMDAC_CODE_RESET && !st_reg.word_valid
            || st_reg.word[`VCMDAC_SLEEP_BIT]) begin
            st_next.code_out = target;
            st_next.tick     = 24'h000000;
        end else if (st_reg.code_out != target) begin
            if (st_reg.tick >= period - 24'h000001) begin
                st_next.tick = 24'h000000;
                if (st_reg.code_out < target) begin
                    st_next.code_out = st_reg.code_out + 10'h001;
                end else begin
                    st_next.code_out = st_reg.code_out - 10'h001;
                end
            end else begin
                st_next.tick = st_reg.tick + 24'h000001;
            end
        end else begin
            st_next.tick = 24'h000000;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg            <= '0;
            st_reg.scl_q1     <= 1'b1;
            st_reg.scl_q2     <= 1'b1;
            st_reg.scl_q3     <= 1'b1;
            st_reg.sda_q1     <= 1'b1;
            st_reg.sda_q2     <= 1'b1;
            st_reg.sda_q3     <= 1'b1;
            st_reg.state      <= vcmdac_pkg::ST_IDLE;
            st_reg.word       <= `VCMDAC_WORD_RESET;
            st_reg.sda_oen    <= 1'b1;
            st_reg.code_out   <= `VCMDAC_CODE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_sda_oen      = st_reg.sda_oen;
    assign o_current_code = st_reg.code_out;
    assign o_sleep        = st_reg.sleep;
    assign o_word_loaded  = st_reg.word_valid;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_addr_done;
        st_reg.state == vcmdac_pkg::ST_ADDR && scl_fall && st_reg.cnt == 4'h8;
    endsequence

    sequence s_read_turn;
        st_reg.state == vcmdac_pkg::ST_AACK && scl_fall && st_reg.rw;
    endsequence

    a_addr_match: assert property (s_addr_done ##1 st_reg.state == vcmdac_pkg::ST_AACK
        |-> $past(st_reg.shift[7:1]) == `VCMDAC_I2C_ADDR && !o_sda_oen)
        else $error("Acknowledge given to a foreign address.");
    a_pin_sync: assert property (##2 st_reg.scl_q2 == $past(i_scl, 2))
        else $error("Serial clock not two stages behind the pin.");
    a_code_bound: assert property ($changed(o_current_code) && ramp_sel != 4'h0
        && st_reg.word_valid && !st_reg.word[15] |-> $past(o_current_code) != $past(target))
        else $error("Ramped output moved while already at its code.");
    a_hold_zero: assert property (!o_word_loaded |-> o_current_code == 10'h000)
        else $error("Output left zero before the first word write.");
    a_sleep_off: assert property (commit && st_reg.hi_byte[7]
        |-> ##2 o_sleep ##1 o_current_code == 10'h000)
        else $error("Power-down bit did not shut the output.");
    // The expected code is rebuilt from the two received bytes, not from the stored word.
    a_code_field: assert property (commit |=> target ==
        ($past(st_reg.hi_byte[7]) ? 10'h000
                                  : {$past(st_reg.hi_byte[5:0]), $past(st_reg.shift[7:4])}))
        else $error("Current code not taken from word bits 13 to 4.");
    a_ramp_step: assert property ($changed(o_current_code) && $past(ramp_sel) != 4'h0
        && $past(st_reg.word_valid) && !$past(st_reg.word[15])
        |-> (o_current_code - $past(o_current_code) == 10'h001)
         || ($past(o_current_code) - o_current_code == 10'h001))
        else $error("Ramp moved by more than one code step.");
    a_read_first: assert property (s_read_turn |=> st_reg.state == vcmdac_pkg::ST_RD
        && o_sda_oen == st_reg.word[15])
        else $error("Read did not start with the word top bit.");
    a_byte_order: assert property (commit |=> st_reg.word ==
        {$past(st_reg.hi_byte), $past(st_reg.shift)} && o_word_loaded)
        else $error("Control word bytes stored out of order.");

endmodule

`default_nettype wire

// File: verilog/vcmdac_defs.svh
/*
 * Constants of the focus coil motor current DAC control block: bus address,
 * control word field positions, reset values and timing figures.
 * Assumes it is included by bare name from the package and the design module.
 */
`ifndef VCMDAC_DEFS_SVH
`define VCMDAC_DEFS_SVH

`define VCMDAC_I2C_ADDR       7'h18
`define VCMDAC_I2C_FMAX_KHZ   400
`define VCMDAC_CLK_PERIOD_NS  20
`define VCMDAC_CODE_BITS      10
`define VCMDAC_FULL_SCALE_MA  100
`define VCMDAC_SLEEP_BIT      15
`define VCMDAC_CODE_MSB       13
`define VCMDAC_CODE_LSB       4
`define VCMDAC_RAMP_MSB       3
`define VCMDAC_RAMP_LSB       0
`define VCMDAC_WORD_RESET     16'h0000
`define VCMDAC_CODE_RESET     10'h000
`define VCMDAC_RAMP_TICK_NS   1000
`define VCMDAC_RAMP_TICK_CYC  ((`VCMDAC_RAMP_TICK_NS) / (`VCMDAC_CLK_PERIOD_NS))

`endif

// File: verilog/vcmdac_pkg.sv
/*
 * Types of the focus coil motor current DAC control block.
 * Assumes vcmdac_defs.svh is on the include path.
 */
`default_nettype none
`include "vcmdac_defs.svh"

package vcmdac_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_WR   = 3'b011,
        ST_WACK = 3'b100,
        ST_RD   = 3'b101,
        ST_RACK = 3'b110
    } vcmdac_state_t;

    typedef struct packed {
        logic                           scl_q1;
        logic                           scl_q2;
        logic                           scl_q3;
        logic                           sda_q1;
        logic                           sda_q2;
        logic                           sda_q3;
        vcmdac_state_t                  state;
        logic [3:0]                     cnt;
        logic [7:0]                     shift;
        logic                           rw;
        logic                           byte_idx;
        logic [7:0]                     hi_byte;
        logic [15:0]                    word;
        logic                           word_valid;
        logic                           sda_oen;
        logic [`VCMDAC_CODE_BITS-1:0]   code_out;
        logic                           sleep;
        logic [23:0]                    tick;
    } vcmdac_regs_t;

endpackage

`default_nettype wire

// File: verif/vcmdac_host.sv
/*
 * Behavioural I2C bus master that stands in for the host controller.
 * Assumes a pull-up on SDA resolved outside as a wired AND of all enables.
 */
`default_nettype none

module vcmdac_host #(
    parameter int Q = 32
) (
    input  wire logic i_clk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda_oen
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        o_scl = 1'b1;
        o_sda_oen = 1'b1;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    // One bit takes 4*Q clocks, about 390 kHz at 50 MHz.
    task automatic bit_io(input logic b, output logic r);
        o_sda_oen = b;
        tk(Q);
        o_scl = 1'b1;
        tk(2 * Q);
        r = i_sda;
        o_scl = 1'b0;
        tk(Q);
    endtask

    task automatic start_c();
        o_sda_oen = 1'b1;
        tk(Q);
        o_scl = 1'b1;
        tk(Q);
        o_sda_oen = 1'b0;
        tk(Q);
        o_scl = 1'b0;
        tk(Q);
    endtask

    task automatic stop_c();
        o_sda_oen = 1'b0;
        tk(Q);
        o_scl = 1'b1;
        tk(Q);
        o_sda_oen = 1'b1;
        tk(2 * Q);
    endtask

    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic ao);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ai, ao);
    endtask

    task automatic wr_word(input logic [6:0] a, input logic [15:0] w, input int nb,
                           output logic [2:0] acks);
        logic [7:0] q;
        start_c();
        xfer({a, 1'b0}, 1'b1, q, acks[2]);
        xfer(w[15:8], 1'b1, q, acks[1]);
        acks[0] = 1'b0;
        if (nb > 1) xfer(w[7:0], 1'b1, q, acks[0]);
        stop_c();
    endtask

    task automatic rd_word(input logic [6:0] a, output logic [15:0] w, output logic a0);
        logic [7:0] q;
        logic       x;
        start_c();
        xfer({a, 1'b1}, 1'b1, q, a0);
        xfer(8'hff, 1'b0, w[15:8], x);
        xfer(8'hff, 1'b1, w[7:0], x);
        stop_c();
    endtask
endmodule

`default_nettype wire

// File: verif/tb.sv
/*
 * Self-checking bench of the focus coil motor current DAC control block.
 * Assumes the host model drives the bus and SDA has a pull-up.
 */
`default_nettype none
`include "vcmdac_defs.svh"

module tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [6:0]  ADDR     = `VCMDAC_I2C_ADDR;
    // A short ramp base keeps the ramp test within a few thousand cycles.
    localparam logic [15:0] RAMP_SIM = 16'h0002;
    typedef struct packed {
        logic [15:0] word;
        logic [9:0]  code;
        logic        slp;
    } vcmdac_row_t;

    logic        clk;
    logic        rst_n;
    wire         scl;
    wire         host_oen;
    wire         dut_oen;
    wire         sda;
    wire [9:0]   code;
    wire         slp;
    wire         loaded;
    int          fails;
    int          cmp_count;
    logic [15:0] rd;
    logic        a0;
    logic [2:0]  acks;
    logic        ok;
    vcmdac_row_t rows [6] = '{{16'h2000, 10'h200, 1'b0}, {16'h3ff0, 10'h3ff, 1'b0},
        {16'h4010, 10'h001, 1'b0}, {16'h8ab0, 10'h000, 1'b1},
        {16'h0550, 10'h055, 1'b0}, {16'h8000, 10'h000, 1'b1}};

    assign sda = host_oen & dut_oen;

    vcmdac_core #(.RAMP_BASE_CYC(RAMP_SIM)) dut_u (
        .i_clk          (clk),
        .i_rst_n        (rst_n),
        .i_scl          (scl),
        .i_sda          (sda),
        .o_sda_oen      (dut_oen),
        .o_current_code (code),
        .o_sleep        (slp),
        .o_word_loaded  (loaded)
    );

    vcmdac_host host_u (
        .i_clk     (clk),
        .i_sda     (sda),
        .o_scl     (scl),
        .o_sda_oen (host_oen)
    );

    always #10 clk = ~clk;

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            fails++;
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (95000) @(posedge clk);
        fails++;
        end_sim();
    end

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        chk("oen", 16'h1, 16'(dut_oen));
        chk("code", 16'h0, 16'(code));
        host_u.tk(4);
        host_u.wr_word(ADDR, 16'h3ff0, 1, acks);
        chk("acks", 16'h0, 16'(acks));
        chk("loaded", 16'h0, 16'(loaded));
        chk("code", 16'h0, 16'(code));
        host_u.wr_word(ADDR + 7'h01, 16'h3ff0, 2, acks);
        chk("acks", 16'h7, 16'(acks));
        chk("loaded", 16'h0, 16'(loaded));
        $display("test hold done");
        foreach (rows[i]) begin
            host_u.wr_word(ADDR, rows[i].word, 2, acks);
            chk("acks", 16'h0, 16'(acks));
            chk("code", 16'(rows[i].code), 16'(code));
            chk("sleep", 16'(rows[i].slp), 16'(slp));
            chk("loaded", 16'h1, 16'(loaded));
            host_u.rd_word(ADDR, rd, a0);
            chk("readback", rows[i].word, rd);
            chk("rd ack", 16'h0, 16'(a0));
        end
        chk("oen idle", 16'h1, 16'(dut_oen));
        $display("test table done");
        host_u.wr_word(ADDR, 16'h0105, 2, acks);
        ok = (code > 10'h000) && (code < 10'h010);
        chk("ramp mid", 16'h1, 16'(ok));
        host_u.tk(1100);
        chk("ramp end", 16'h010, 16'(code));
        host_u.wr_word(ADDR, 16'h8105, 2, acks);
        chk("sleep code", 16'h0, 16'(code));
        chk("sleep flag", 16'h1, 16'(slp));
        $display("test ramp done");
        rst_n = 1'b0;
        host_u.tk(2);
        chk("rst sleep", 16'h0, 16'(slp));
        chk("rst loaded", 16'h0, 16'(loaded));
        rst_n = 1'b1;
        host_u.tk(4);
        host_u.rd_word(ADDR, rd, a0);
        chk("rst word", 16'h0000, rd);
        $display("test reset done");
        end_sim();
    end
endmodule

`default_nettype wire
